/* File: dv/serial_link_frame_mapper_bench.sv */
// Self-checking bench for the serial link frame mapper
`default_nettype none
module serial_link_frame_mapper_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// Short gates keep the run brief
	localparam logic [15:0] PU = 16'h0028;
	localparam logic [15:0] RS = 16'h0014;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] strap_lo = 2'h0;
	logic [1:0] strap_hi = 2'h0;
	logic width_sel = 1'b0;
	logic [28:0] lane = 29'h0;
	logic fwd_ctl = 1'b0;
	logic link_on = 1'b0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata, rev_data, rx_data;
	logic rvalid, fvalid, rev_valid, rev_ready, rx_valid;
	logic [39:0] syms;
	logic [2:0] nsym;
	int frames, f0;
	int err_total = 0;
	int cmp_count = 0;

	always #20 ref_clk = ~ref_clk;

	// Busy inputs; forward control toggles to show the reverse path ignores it
	always @(posedge ref_clk) begin
		lane <= lane + 29'h1;
		fwd_ctl <= ~fwd_ctl;
	end

	slfm_frame_mapper #(.POWERUP_CYC(PU), .RESTART_CYC(RS)) dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .addr_strap_low(strap_lo), .addr_strap_high(strap_hi),
		.lane_width_select(width_sel), .lvds_word(lane), .aux_control_one(lane[3]),
		.aux_control_two(lane[5]), .audio_data_or_control_zero(lane[1]), .i2s_bit_clk(lane[0]),
		.i2s_word_sel(lane[4]), .forward_control_bit(fwd_ctl), .encrypt_enable(lane[6]),
		.cipher_stream({3'h0, lane}), .link_active(link_on), .rev_rx_data(rx_data),
		.rev_rx_valid(rx_valid), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
		.reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .frame_valid(fvalid),
		.frame_symbols(syms), .frame_sym_count(nsym), .rev_data(rev_data), .rev_valid(rev_valid),
		.rev_ready(rev_ready)
	);

	slfm_far_end far (.ref_clk(ref_clk), .frame_valid(fvalid), .rev_rx_data(rx_data),
		.rev_rx_valid(rx_valid), .frame_count(frames));

	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Reset held three cycles; registers usable from the sixth edge
	task automatic do_reset();
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask

	// Read answer is registered on the taking edge and checked just after it
	task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1;
		check(40'({rvalid, rdata}), 40'({1'b1, exp}));
	endtask

	task automatic send_chk(input logic [7:0] w, input logic taken);
		far.send_word(w);
		#1;
		check(40'(rev_valid), 40'(taken));
		if (taken) begin
			check(40'(rev_data), 40'(w));
		end
	endtask

	// Bounded wait for the reverse gate to open
	task automatic wait_ready(input int bound);
		for (int i = 0; i < bound; i++) begin
			@(posedge ref_clk);
			#1;
			if (rev_ready === 1'b1) return;
		end
		err_total++;
		$display("wrong value at %0t: seen %h expected %h", $time, rev_ready, 1'b1);
		final_report();
	endtask

	function automatic logic [7:0] addr_exp(input int h, input int l, input logic side);
		return {(h == 0) ? 3'h4 : (h == 1) ? 3'h6 : 3'h2, side, (l == 0) ? 2'h0 : (l == 1) ? 2'h1 : 2'h2, 2'h0};
	endfunction

	initial begin
		// Every strap pair, relatched on each reset
		for (int i = 0; i < 9; i++) begin
			@(posedge ref_clk);
			strap_hi <= 2'(i / 3);
			strap_lo <= 2'(i % 3);
			do_reset();
			reg_read(slfm_pkg::ADDR_A_OFS, addr_exp(i / 3, i % 3, 1'b0));
			reg_read(slfm_pkg::ADDR_B_OFS, addr_exp(i / 3, i % 3, 1'b1));
		end
		$display("strap address test done");
		// Register access, fixed bits and an unmapped place
		reg_read(slfm_pkg::CFG_OFS, 8'h01);
		reg_write(slfm_pkg::ADDR_A_OFS, 8'hff);
		reg_write(slfm_pkg::ADDR_B_OFS, 8'h00);
		reg_write(slfm_pkg::CFG_OFS, 8'hff);
		reg_write(8'h05, 8'hff);
		reg_read(slfm_pkg::ADDR_A_OFS, 8'hee);
		reg_read(slfm_pkg::ADDR_B_OFS, 8'h10);
		reg_read(slfm_pkg::CFG_OFS, 8'h11);
		// Audio off: data pin becomes plain control for the frame test
		reg_write(slfm_pkg::CFG_OFS, 8'h10);
		reg_read(slfm_pkg::CFG_OFS, 8'h10);
		reg_read(8'h05, 8'h00);
		$display("register test done");
		// Frame shape in both widths, one frame per clock
		check(40'(fvalid), 40'h1);
		check(40'(nsym), 40'(slfm_pkg::SYMS3));
		check(40'(syms[39:30]), 40'h0);
		// Every coded symbol holds four to six ones
		for (int k = 0; k < 3; k++) begin
			check(40'(($countones(syms[k * 10 +: 10]) inside {[4:6]})), 40'h1);
		end
		f0 = frames;
		repeat (20) @(posedge ref_clk);
		#1;
		check(40'(frames - f0), 40'd20);
		@(posedge ref_clk);
		width_sel <= 1'b1;
		repeat (8) @(posedge ref_clk);
		#1;
		check(40'(nsym), 40'(slfm_pkg::SYMS4));
		for (int k = 0; k < 4; k++) begin
			check(40'(($countones(syms[k * 10 +: 10]) inside {[4:6]})), 40'h1);
		end
		$display("frame test done");
		// Reverse channel closed after power-up, then open
		do_reset();
		#1;
		check(40'(rev_ready), 40'h0);
		send_chk(8'h5a, 1'b0);
		repeat (24) @(posedge ref_clk);
		#1;
		check(40'(rev_ready), 40'h0);
		wait_ready(30);
		send_chk(8'ha5, 1'b1);
		send_chk(8'h3c, 1'b1);
		// Link start then stop each blank the reverse channel
		for (int v = 1; v >= 0; v--) begin
			@(posedge ref_clk);
			link_on <= v[0];
			repeat (3) @(posedge ref_clk);
			#1;
			check(40'(rev_ready), 40'h0);
			send_chk(8'h77, 1'b0);
			repeat (10) @(posedge ref_clk);
			#1;
			check(40'(rev_ready), 40'h0);
			wait_ready(30);
			send_chk(8'hc3, 1'b1);
		end
		$display("reverse channel test done");
		final_report();
	end

	// Run limit
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		$display("run limit reached at %0t", $time);
		final_report();
	end
endmodule
`default_nettype wire

/* File: dv/slfm_far_end.sv */
// Far-end model: reverse channel sender and forward frame counter
`default_nettype none
module slfm_far_end (
	input wire logic ref_clk,
	input wire logic frame_valid,
	output logic [7:0] rev_rx_data,
	output logic rev_rx_valid,
	output int frame_count
);
	timeunit 1ns;
	timeprecision 1ps;

	// Quiet line at start
	initial begin
		rev_rx_data = 8'h00;
		rev_rx_valid = 1'b0;
		frame_count = 0;
	end

	// Count every frame delivered on the link
	always @(posedge ref_clk) begin
		if (frame_valid) begin
			frame_count <= frame_count + 1;
		end
	end

	// One-cycle word strobe; idle data inverted so a stale byte never looks fresh
	task automatic send_word(input logic [7:0] w);
		@(posedge ref_clk);
		rev_rx_valid <= 1'b1;
		rev_rx_data <= w;
		@(posedge ref_clk);
		rev_rx_valid <= 1'b0;
		rev_rx_data <= ~w;
	endtask
endmodule
`default_nettype wire

/* File: rtl/slfm_frame_mapper.sv */
// Forward-link frame mapper with address straps and reverse channel gate
// Behaviour
// - Address bit 4: serializer 0, deserializer 1
// - Default addresses come from the two straps
// - Map lane bits to colour, sync, aux fields
// - Encrypt colour and audio, never sync/aux
// - Scramble then 8b/10b encode every frame
// - Frame carries 21 or 29 lane bits
// - One audio bit from the three I2S inputs
// - One forward control bit per frame
// - Last bit is parity of preceding bits
// - Four-lane default sends reserved bit 27
// - Reserved-disable puts aux control one at 27
// - Reverse channel delivers deserializer traffic here
// - Reverse channel independent of forward control
// - Reverse channel usable 500 us after power-up
// - Link start/stop blanks reverse channel 350 us
// - Width strap low three lanes, high four
// - Straps relatched after every power-up or resume
// - Audio disabled: data pin is plain control
`default_nettype none
module slfm_frame_mapper #(
	parameter logic [15:0] POWERUP_CYC = 16'(slfm_pkg::POWERUP_CYC),
	parameter logic [15:0] RESTART_CYC = 16'(slfm_pkg::RESTART_CYC),
	parameter logic ODD_PARITY = 1'b0,
	parameter logic [15:0] SCR_TAPS = slfm_pkg::SCR_TAPS
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [1:0] addr_strap_low,
	input wire logic [1:0] addr_strap_high,
	input wire logic lane_width_select,
	input wire logic [28:0] lvds_word,
	input wire logic aux_control_one,
	input wire logic aux_control_two,
	input wire logic audio_data_or_control_zero,
	input wire logic i2s_bit_clk,
	input wire logic i2s_word_sel,
	input wire logic forward_control_bit,
	input wire logic encrypt_enable,
	input wire logic [31:0] cipher_stream,
	input wire logic link_active,
	input wire logic [7:0] rev_rx_data,
	input wire logic rev_rx_valid,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	output logic frame_valid,
	output logic [39:0] frame_symbols,
	output logic [2:0] frame_sym_count,
	output logic [7:0] rev_data,
	output logic rev_valid,
	output logic rev_ready
);
	// Strap decode to address fields
	function automatic logic [2:0] slfm_hi_field(input logic [1:0] code);
		case (code)
			slfm_pkg::STRAP_LOW: return 3'h4;
			slfm_pkg::STRAP_HIGH: return 3'h6;
			default: return 3'h2;
		endcase
	endfunction

	function automatic logic [1:0] slfm_lo_field(input logic [1:0] code);
		case (code)
			slfm_pkg::STRAP_LOW: return 2'h0;
			slfm_pkg::STRAP_HIGH: return 2'h1;
			default: return 2'h2;
		endcase
	endfunction

	// One byte through 8b/10b, returns {rd_out, abcdei, fghj}
	function automatic logic [10:0] slfm_enc(input logic [7:0] d, input logic rd);
		logic [5:0] c6;
		logic [3:0] c4;
		logic u6, u4, rd1, alt;
		c6 = slfm_pkg::SIXB[d[4:0]];
		u6 = ($countones(c6) != 3);
		if (rd && (u6 || c6 == 6'h38)) begin
			c6 = ~c6;
		end
		rd1 = rd ^ u6;
		c4 = slfm_pkg::FOURB[d[7:5]];
		// Alternate D.x.7 keeps run length at five
		alt = (d[7:5] == 3'h7) && ((!rd1 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14)) ||
			(rd1 && (d[4:0] == 5'h0b || d[4:0] == 5'h0d || d[4:0] == 5'h0e)));
		if (alt) begin
			c4 = 4'h7;
		end
		u4 = ($countones(c4) != 2);
		if (rd1 && (u4 || c4 == 4'hc)) begin
			c4 = ~c4;
		end
		return {rd1 ^ u4, c6, c4};
	endfunction

	// Pin synchronisers, three stages, filtered on agreement
	logic [7:0] pin_vec, s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
	assign pin_vec = {addr_strap_high, addr_strap_low, lane_width_select, audio_data_or_control_zero,
		i2s_bit_clk, i2s_word_sel};
	assign filt_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= 8'h00;
			s2_reg <= 8'h00;
			s3_reg <= 8'h00;
			filt_reg <= 8'h00;
		end else begin
			s1_reg <= pin_vec;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			filt_reg <= filt_next;
		end
	end

	logic [1:0] strap_hi, strap_lo;
	logic wide, sd_q, sck_q, ws_q;
	assign strap_hi = filt_reg[7:6];
	assign strap_lo = filt_reg[5:4];
	assign wide = filt_reg[3];
	assign sd_q = filt_reg[2];
	assign sck_q = filt_reg[1];
	assign ws_q = filt_reg[0];

	// Strap capture a few edges after every reset release
	logic [2:0] latch_cnt_reg;
	logic strap_load;
	assign strap_load = (latch_cnt_reg == slfm_pkg::STRAP_LOAD_CNT);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_cnt_reg <= 3'h0;
		end else if (latch_cnt_reg <= slfm_pkg::STRAP_LOAD_CNT) begin
			latch_cnt_reg <= latch_cnt_reg + 3'h1;
		end
	end

	// Register file: addresses and configuration
	logic [7:0] addr_a_reg, addr_b_reg, cfg_reg, strap_addr, rd_mux;
	logic wr_a, wr_b, wr_cfg, audio_en, rsv_dis;
	assign strap_addr = {slfm_hi_field(strap_hi), 1'b0, slfm_lo_field(strap_lo), 2'b00};
	assign wr_a = reg_wr_en && reg_addr == slfm_pkg::ADDR_A_OFS;
	assign wr_b = reg_wr_en && reg_addr == slfm_pkg::ADDR_B_OFS;
	assign wr_cfg = reg_wr_en && reg_addr == slfm_pkg::CFG_OFS;
	assign rd_mux = (reg_addr == slfm_pkg::ADDR_A_OFS) ? addr_a_reg :
		(reg_addr == slfm_pkg::ADDR_B_OFS) ? addr_b_reg :
		(reg_addr == slfm_pkg::CFG_OFS) ? cfg_reg : 8'h00;
	assign audio_en = cfg_reg[slfm_pkg::CFG_AUDIO_EN_BIT];
	assign rsv_dis = cfg_reg[slfm_pkg::CFG_RSV_DIS_BIT];

	// Direction bit forced per register; bit 0 is the read/write slot
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_a_reg <= 8'h00;
			addr_b_reg <= 8'h00;
		end else if (strap_load) begin
			addr_a_reg <= strap_addr;
			addr_b_reg <= strap_addr | 8'h10;
		end else begin
			if (wr_a) begin
				addr_a_reg <= {reg_wdata[7:5], 1'b0, reg_wdata[3:1], 1'b0};
			end
			if (wr_b) begin
				addr_b_reg <= {reg_wdata[7:5], 1'b1, reg_wdata[3:1], 1'b0};
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= slfm_pkg::CFG_RST;
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			if (wr_cfg) begin
				cfg_reg <= reg_wdata & slfm_pkg::CFG_WMASK;
			end
			reg_rvalid <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rdata <= rd_mux;
			end
		end
	end

	// Audio bit rotates through data, bit clock and word select
	logic [1:0] aph_reg;
	logic audio_bit;
	assign audio_bit = !audio_en ? sd_q : (aph_reg == 2'h0) ? sd_q : (aph_reg == 2'h1) ? sck_q : ws_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			aph_reg <= 2'h0;
		end else begin
			aph_reg <= (aph_reg == 2'h2) ? 2'h0 : aph_reg + 2'h1;
		end
	end

	// Frame assembly, one per clock
	logic [28:0] din4;
	logic [30:0] body4, body3, body;
	logic par_bit;
	logic [31:0] frame_next, mask, crypt_next;
	assign din4 = {aux_control_two, rsv_dis ? aux_control_one : lvds_word[slfm_pkg::RSV_POS],
		lvds_word[26:0]};
	assign body4 = {forward_control_bit, audio_bit, din4};
	assign body3 = {8'h00, forward_control_bit, audio_bit, lvds_word[20:0]};
	assign body = wide ? body4 : body3;
	assign par_bit = ^body ^ ODD_PARITY;
	assign frame_next = wide ? {par_bit, body4} : {8'h00, par_bit, body3[22:0]};
	// Sync, enable, reserved and aux never enter the mask
	assign mask = wide ? (slfm_pkg::MASK4_COLOR | (32'(audio_en) << slfm_pkg::AUDIO_POS4)) :
		(slfm_pkg::MASK3_COLOR | (32'(audio_en) << slfm_pkg::AUDIO_POS3));
	assign crypt_next = frame_next ^ (cipher_stream & mask & {32{encrypt_enable}});

	logic [31:0] frame_reg, crypt_reg;
	logic wide_reg, fv1_reg;

	// Plain frame kept beside the ciphered one
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_reg <= 32'h0;
			crypt_reg <= 32'h0;
			wide_reg <= 1'b0;
			fv1_reg <= 1'b0;
		end else begin
			frame_reg <= frame_next;
			crypt_reg <= crypt_next;
			wide_reg <= wide;
			fv1_reg <= 1'b1;
		end
	end

	// Additive scrambler; the 16-bit stream repeats over both halves
	logic [15:0] lfsr_reg;
	logic [31:0] scr;
	logic [10:0] e0, e1, e2, e3;
	logic rd_reg, rd_next;
	assign scr = crypt_reg ^ {lfsr_reg, lfsr_reg};
	assign e0 = slfm_enc(scr[7:0], rd_reg);
	assign e1 = slfm_enc(scr[15:8], e0[10]);
	assign e2 = slfm_enc(scr[23:16], e1[10]);
	assign e3 = slfm_enc(scr[31:24], e2[10]);
	assign rd_next = wide_reg ? e3[10] : e2[10];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lfsr_reg <= slfm_pkg::SCR_SEED;
			rd_reg <= 1'b0;
			frame_valid <= 1'b0;
			frame_symbols <= 40'h0;
			frame_sym_count <= 3'h0;
		end else begin
			frame_valid <= fv1_reg;
			if (fv1_reg) begin
				lfsr_reg <= {lfsr_reg[14:0], ^(lfsr_reg & SCR_TAPS)};
				rd_reg <= rd_next;
				frame_symbols <= {wide_reg ? e3[9:0] : 10'h0, e2[9:0], e1[9:0], e0[9:0]};
				frame_sym_count <= wide_reg ? slfm_pkg::SYMS4 : slfm_pkg::SYMS3;
			end
		end
	end

	// Reverse channel gate; never looks at the forward control bit
	logic [15:0] gate_reg;
	logic link_q_reg, link_edge;
	assign link_edge = link_active ^ link_q_reg;
	assign rev_ready = (gate_reg == 16'h0);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gate_reg <= POWERUP_CYC;
			link_q_reg <= 1'b0;
			rev_data <= 8'h00;
			rev_valid <= 1'b0;
		end else begin
			link_q_reg <= link_active;
			// A restart never shortens the power-up blank
			if (link_edge && gate_reg < RESTART_CYC) begin
				gate_reg <= RESTART_CYC;
			end else if (gate_reg != 16'h0) begin
				gate_reg <= gate_reg - 16'h1;
			end
			rev_valid <= rev_rx_valid && rev_ready;
			if (rev_rx_valid && rev_ready) begin
				rev_data <= rev_rx_data;
			end
		end
	end

	// Checking helpers
	logic [15:0] since_rst_reg;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			since_rst_reg <= 16'h0;
		end else if (since_rst_reg != 16'hffff) begin
			since_rst_reg <= since_rst_reg + 16'h1;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_addr_dir;
		strap_load |=> !addr_a_reg[4] && addr_b_reg[4] && addr_b_reg == (addr_a_reg | 8'h10);
	endproperty
	a_addr_dir: assert property (p_addr_dir) else $error("address direction bit wrong");

	property p_strap_addr;
		strap_load |=> addr_a_reg == {slfm_hi_field($past(strap_hi)), 1'b0, slfm_lo_field($past(strap_lo)), 2'b00};
	endproperty
	a_strap_addr: assert property (p_strap_addr) else $error("strap address not loaded");

	property p_parity;
		fv1_reg |-> (^frame_reg ^ ODD_PARITY) == 1'b0;
	endproperty
	a_parity: assert property (p_parity) else $error("frame parity wrong");

	property p_three_lane;
		fv1_reg && !wide_reg |-> frame_reg[31:24] == 8'h00;
	endproperty
	a_three_lane: assert property (p_three_lane) else $error("three-lane frame too wide");

	property p_rsv_slot;
		wide && fv1_reg ##1 1'b1 |-> frame_reg[27] == ($past(rsv_dis) ? $past(aux_control_one) : $past(lvds_word[27]));
	endproperty
	a_rsv_slot: assert property (p_rsv_slot) else $error("reserved slot wrong");

	property p_clear_fields;
		mask[20:18] == 3'h0 && mask[28:27] == 2'h0 && mask[31:30] == 2'h0;
	endproperty
	a_clear_fields: assert property (p_clear_fields) else $error("sync or aux bit encrypted");

	property p_powerup;
		rev_ready |-> since_rst_reg >= POWERUP_CYC;
	endproperty
	a_powerup: assert property (p_powerup) else $error("reverse channel open too early");

	property p_restart;
		link_edge |=> !rev_ready [*8];
	endproperty
	a_restart: assert property (p_restart) else $error("reverse channel not blanked");

	property p_sym_count;
		fv1_reg |=> frame_valid && frame_sym_count == ($past(wide_reg) ? slfm_pkg::SYMS4 : slfm_pkg::SYMS3);
	endproperty
	a_sym_count: assert property (p_sym_count) else $error("symbol count wrong");

	c_four_lane: cover property (fv1_reg && wide_reg);
	c_three_lane: cover property (fv1_reg && !wide_reg);
	c_rsv_dis: cover property (wide && rsv_dis);
	c_rev_open: cover property (rev_valid);
endmodule
`default_nettype wire

/* File: rtl/slfm_pkg.sv */
// Constants shared by the serial link frame mapper
`default_nettype none
package slfm_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_A_OFS = 8'h00;
	localparam logic [7:0] ADDR_B_OFS = 8'h01;
	localparam logic [7:0] CFG_OFS = 8'h0d;
	// Config register fields and reset value
	localparam int CFG_AUDIO_EN_BIT = 0;
	localparam int CFG_RSV_DIS_BIT = 4;
	localparam logic [7:0] CFG_RST = 8'h01;
	localparam logic [7:0] CFG_WMASK = 8'h11;
	// Device address fields
	localparam int ADDR_DIR_BIT = 4;
	// Three-level strap codes
	localparam logic [1:0] STRAP_LOW = 2'h0;
	localparam logic [1:0] STRAP_HIGH = 2'h1;
	localparam logic [1:0] STRAP_OPEN = 2'h2;
	localparam logic [2:0] STRAP_LOAD_CNT = 3'h4;
	// Frame layout
	localparam int LANES3_BITS = 21;
	localparam int LANES4_BITS = 29;
	localparam int RSV_POS = 27;
	localparam logic [31:0] MASK4_COLOR = 32'h07e3ffff;
	localparam logic [31:0] MASK3_COLOR = 32'h0003ffff;
	localparam int AUDIO_POS3 = 21;
	localparam int AUDIO_POS4 = 29;
	localparam logic [2:0] SYMS3 = 3'h3;
	localparam logic [2:0] SYMS4 = 3'h4;
	// Scrambler defaults
	localparam logic [15:0] SCR_TAPS = 16'hb400;
	localparam logic [15:0] SCR_SEED = 16'hffff;
	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int POWERUP_NS = 500000;
	localparam int RESTART_NS = 350000;
	localparam int POWERUP_CYC = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESTART_CYC = (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// 8b/10b tables, running disparity negative
	localparam logic [5:0] SIXB [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
		6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
	localparam logic [3:0] FOURB [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
endpackage
`default_nettype wire
